/* File: common/tsi_consts.vh */
// Purpose: Constants for the touch stage interrupt status block.
// Assumes: Registers are 16 bits wide, eight stages in the low byte.
// Notes: Offsets are register addresses on the device's internal register port.
`ifndef TSI_CONSTS_VH
`define TSI_CONSTS_VH
`define TSI_ADDR_W           10
`define TSI_DATA_W           16
`define TSI_STAGES           8
`define TSI_ADDR_HIGH_EN     10'h006
`define TSI_ADDR_DONE_EN     10'h007
`define TSI_ADDR_LOW_FLAGS   10'h008
`define TSI_ADDR_HIGH_FLAGS  10'h009
`define TSI_ADDR_LOW_EN      10'h005
`define TSI_RESET_ENABLE     8'h00
`define TSI_RESET_FLAGS      8'h00
`endif

/* File: src/tsi_limit_flags.v */
// Purpose: Eight sticky limit flags that self-clear on readback.
// Assumes: All inputs come from logic on sys_clk_in.
// Notes: A flag whose limit is still exceeded survives the read.
`timescale 1ns/1ns
`include "tsi_consts.vh"
module tsi_limit_flags #(
    parameter STAGES = `TSI_STAGES
) (
    input  wire              sys_clk_in,
    input  wire              rst_b_in,
    input  wire [STAGES-1:0] exceed_in,
    input  wire              read_clear_in,
    output reg  [STAGES-1:0] flags_out
);
    wire [STAGES-1:0] next_flags;
    genvar g;
    generate
        for (g = 0; g < STAGES; g = g + 1) begin : g_flag
            assign next_flags[g] = exceed_in[g] | (flags_out[g] & ~read_clear_in);
        end
    endgenerate

    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flags_out <= {STAGES{1'b0}};
        end else begin
            flags_out <= next_flags;
        end
    end
endmodule // tsi_limit_flags

/* File: src/tsi_irq_status.v */
// Purpose: Per-stage interrupt enables, limit status flags and interrupt output.
// Assumes: The register port and event inputs come from logic on sys_clk_in.
// Notes: Read data is registered; a read of a flag register clears its flags in the same edge it loads rd_data_out.
// Behaviour
// - Enabled completion asserts interrupt output.
// - Disabled completion ignored; enables reset zero.
// - Low threshold exceeded sets low flag.
// - High threshold exceeded sets high flag.
// - Read clears flags unless still exceeded.
// - Limit flags read-only, zero after reset.
// - Enabled high limit asserts interrupt.
// - Enabled low limit asserts interrupt.
`timescale 1ns/1ns
`include "tsi_consts.vh"
module tsi_irq_status #(
    parameter STAGES = `TSI_STAGES
) (
    input  wire                     sys_clk_in,
    input  wire                     rst_b_in,
    input  wire [`TSI_ADDR_W-1:0]   addr_in,
    input  wire                     wr_en_in,
    input  wire                     rd_en_in,
    input  wire [`TSI_DATA_W-1:0]   wr_data_in,
    output reg  [`TSI_DATA_W-1:0]   rd_data_out,
    output reg                      rd_hit_out,
    input  wire [STAGES-1:0]        stage_done_in,
    input  wire [STAGES-1:0]        low_exceed_in,
    input  wire [STAGES-1:0]        high_exceed_in,
    output reg                      irq_b_out
);
    reg  [STAGES-1:0]      done_en;
    reg  [STAGES-1:0]      low_en;
    reg  [STAGES-1:0]      high_en;
    reg  [STAGES-1:0]      done_pend;
    reg  [STAGES-1:0]      next_done_en;
    reg  [STAGES-1:0]      next_low_en;
    reg  [STAGES-1:0]      next_high_en;
    reg  [STAGES-1:0]      next_done_pend;
    wire [STAGES-1:0]      low_flags;
    wire [STAGES-1:0]      high_flags;
    wire [STAGES-1:0]      stage_src;
    reg  [`TSI_DATA_W-1:0] next_rd_data;
    reg                    next_hit;
    reg                    next_irq_b;

    // One select bit per mapped register; an unmapped address selects nothing.
    localparam SEL_LOW_EN     = 0;
    localparam SEL_HIGH_EN    = 1;
    localparam SEL_DONE_EN    = 2;
    localparam SEL_LOW_FLAGS  = 3;
    localparam SEL_HIGH_FLAGS = 4;
    localparam SEL_W          = 5;

    function [STAGES-1:0] low_byte;
        input [`TSI_DATA_W-1:0] d;
        begin
            low_byte = d[STAGES-1:0];
        end
    endfunction

    // Only the low byte is stored, so stray upper bits from the host never come back on a read.
    function [STAGES-1:0] enable_update;
        input [STAGES-1:0]      cur;
        input                   hit;
        input [`TSI_DATA_W-1:0] d;
        begin
            if (hit) begin
                enable_update = low_byte(d);
            end else begin
                enable_update = cur;
            end
        end
    endfunction

    function [SEL_W-1:0] reg_select;
        input [`TSI_ADDR_W-1:0] a;
        begin
            reg_select = {SEL_W{1'b0}};
            case (a)
                `TSI_ADDR_LOW_EN: begin
                    reg_select[SEL_LOW_EN] = 1'b1;
                end
                `TSI_ADDR_HIGH_EN: begin
                    reg_select[SEL_HIGH_EN] = 1'b1;
                end
                `TSI_ADDR_DONE_EN: begin
                    reg_select[SEL_DONE_EN] = 1'b1;
                end
                `TSI_ADDR_LOW_FLAGS: begin
                    reg_select[SEL_LOW_FLAGS] = 1'b1;
                end
                `TSI_ADDR_HIGH_FLAGS: begin
                    reg_select[SEL_HIGH_FLAGS] = 1'b1;
                end
                default: begin
                    reg_select = {SEL_W{1'b0}};
                end
            endcase
        end
    endfunction

    wire [SEL_W-1:0] addr_sel = reg_select(addr_in);
    wire [SEL_W-1:0] wr_sel   = addr_sel & {SEL_W{wr_en_in}};
    wire [SEL_W-1:0] rd_sel   = addr_sel & {SEL_W{rd_en_in}};
    wire             rd_low   = rd_sel[SEL_LOW_FLAGS];
    wire             rd_high  = rd_sel[SEL_HIGH_FLAGS];

    tsi_limit_flags #(.STAGES(STAGES)) u_low (
        .sys_clk_in    (sys_clk_in),
        .rst_b_in      (rst_b_in),
        .exceed_in     (low_exceed_in),
        .read_clear_in (rd_low),
        .flags_out     (low_flags)
    );

    tsi_limit_flags #(.STAGES(STAGES)) u_high (
        .sys_clk_in    (sys_clk_in),
        .rst_b_in      (rst_b_in),
        .exceed_in     (high_exceed_in),
        .read_clear_in (rd_high),
        .flags_out     (high_flags)
    );

    always @* begin
        next_done_en = enable_update(done_en, wr_sel[SEL_DONE_EN], wr_data_in);
        next_low_en  = enable_update(low_en, wr_sel[SEL_LOW_EN], wr_data_in);
        next_high_en = enable_update(high_en, wr_sel[SEL_HIGH_EN], wr_data_in);
    end

    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            done_en <= `TSI_RESET_ENABLE;
            low_en  <= `TSI_RESET_ENABLE;
            high_en <= `TSI_RESET_ENABLE;
        end else begin
            done_en <= next_done_en;
            low_en  <= next_low_en;
            high_en <= next_high_en;
        end
    end

    // Completion is a pulse, so it is held until a write of the enable register acknowledges it.
    // A pulse in the same cycle as that write survives, since dropping it would hide a finished stage.
    // Completion latched, set wins.
    always @* begin
        if (wr_sel[SEL_DONE_EN]) begin
            next_done_pend = stage_done_in;
        end else begin
            next_done_pend = done_pend | stage_done_in;
        end
    end

    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            done_pend <= {STAGES{1'b0}};
        end else begin
            done_pend <= next_done_pend;
        end
    end

    // Each stage folds its three enabled sources into one request bit.
    genvar g;
    generate
        for (g = 0; g < STAGES; g = g + 1) begin : g_src
            assign stage_src[g] = (done_en[g] & done_pend[g]) |
                                  (high_en[g] & high_flags[g]) |
                                  (low_en[g] & low_flags[g]);
        end
    endgenerate

    always @* begin
        next_rd_data = {`TSI_DATA_W{1'b0}};
        next_hit     = 1'b1;
        case (addr_in)
            `TSI_ADDR_LOW_EN: begin
                next_rd_data[STAGES-1:0] = low_en;
            end
            `TSI_ADDR_HIGH_EN: begin
                next_rd_data[STAGES-1:0] = high_en;
            end
            `TSI_ADDR_DONE_EN: begin
                next_rd_data[STAGES-1:0] = done_en;
            end
            `TSI_ADDR_LOW_FLAGS: begin
                next_rd_data[STAGES-1:0] = low_flags;
            end
            `TSI_ADDR_HIGH_FLAGS: begin
                next_rd_data[STAGES-1:0] = high_flags;
            end
            default: begin
                next_hit = 1'b0;
            end
        endcase
    end

    // Read data stands until the next read, so the host may sample it late.
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_data_out <= {`TSI_DATA_W{1'b0}};
            rd_hit_out  <= 1'b0;
        end else if (rd_en_in) begin
            rd_data_out <= next_rd_data;
            rd_hit_out  <= next_hit;
        end
    end

    always @* begin
        next_irq_b = ~(|stage_src);
    end

    // The pin is registered so that a glitch in the source logic never reaches the host.
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_b_out <= 1'b1;
        end else begin
            irq_b_out <= next_irq_b;
        end
    end
endmodule // tsi_irq_status

/* File: test/tsi_irq_status_props.sv */
// Purpose: Port checks for the stage interrupt block.
// Assumes: One clock, reset active low.
// Notes: Sees only the top-level ports.
`timescale 1ns/1ns
module tsi_irq_status_props (
    input logic        sys_clk_in,
    input logic        rst_b_in,
    input logic [9:0]  addr_in,
    input logic        wr_en_in,
    input logic        rd_en_in,
    input logic [15:0] wr_data_in,
    input logic [15:0] rd_data_out,
    input logic        rd_hit_out,
    input logic [7:0]  stage_done_in,
    input logic [7:0]  low_exceed_in,
    input logic [7:0]  high_exceed_in,
    input logic        irq_b_out
);
    wire lo_rd = rd_en_in && addr_in == 10'h008;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    hi_zero_a: assert property (rd_data_out[15:8] == 8'h00) else $error("hi bits");
    lo_set_a: assert property (lo_rd |=> &(rd_data_out[7:0] | ~$past(low_exceed_in, 2)))
        else $error("lo flag");
    hi_set_a: assert property (rd_en_in && addr_in == 10'h009 |=>
        &(rd_data_out[7:0] | ~$past(high_exceed_in, 2))) else $error("hi flag");
    rd_clear_a: assert property ((lo_rd && !low_exceed_in)[*2] |=> !rd_data_out) else $error("clear");
    map_hit_a: assert property (rd_en_in |=> rd_hit_out == ($past(addr_in) inside {[10'h005:10'h009]}))
        else $error("hit");
    en_echo_a: assert property (wr_en_in && addr_in == 10'h007 ##1 rd_en_in && addr_in == 10'h007
        |=> rd_data_out == $past(wr_data_in, 2)) else $error("enable");
    irq_rel_a: assert property ($rose(irq_b_out) |-> $past(wr_en_in, 2) || $past(rd_en_in, 2))
        else $error("release");
    irq_src_a: assert property ($fell(irq_b_out) |-> $past(wr_en_in, 2) || |$past(stage_done_in, 2)
        || |$past(low_exceed_in, 2) || |$past(high_exceed_in, 2)) else $error("source");
    cover property (lo_rd ##1 rd_data_out != 16'h0000);
    cover property ($fell(irq_b_out));
    cover property ($rose(irq_b_out));
endmodule // tsi_irq_status_props

/* File: test/tsi_host_model.sv */
// Purpose: Host model driving the register port.
// Assumes: Strobes change just after a rising edge.
// Notes: Read cycles leave the data lines toggling.
`timescale 1ns/1ns
module tsi_host_model (
    input  wire        sys_clk_in,
    output reg  [9:0]  addr_out = 10'h000,
    output reg         wr_en_out = 1'h0,
    output reg         rd_en_out = 1'h0,
    output reg  [15:0] wr_data_out = 16'h0000
);
    task acc(input w, input [9:0] a, input [7:0] d);
        addr_out <= a;
        wr_en_out <= w;
        rd_en_out <= !w;
        wr_data_out <= w ? {8'h00, d} : ~wr_data_out;
        @(posedge sys_clk_in);
    endtask
    task idle;
        wr_en_out <= 1'h0;
        rd_en_out <= 1'h0;
        @(posedge sys_clk_in);
    endtask
endmodule // tsi_host_model

/* File: test/testbench.sv */
// Purpose: Self-checking bench for the stage interrupt block.
// Assumes: The host model owns the register port.
// Notes: Reads are checked against a queue of expected words.
`timescale 1ns/1ns
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_errors++; $display("[ERR] %s exp %h saw %h", n, e, s); end end
module testbench;
    logic        sys_clk_in = 0;
    logic        rst_b_in = 0;
    logic [7:0]  stage_done_in = 0, low_exceed_in = 0, high_exceed_in = 0, s;
    wire  [9:0]  addr_in;
    wire  [15:0] wr_data_in, rd_data_out;
    wire         wr_en_in, rd_en_in, rd_hit_out, irq_b_out;
    logic [16:0] exp_q[$];
    logic [16:0] exp_w;
    int          n_errors = 0, num_checks = 0;
    always #5 sys_clk_in = ~sys_clk_in;
    tsi_host_model host (.sys_clk_in, .addr_out(addr_in), .wr_en_out(wr_en_in),
        .rd_en_out(rd_en_in), .wr_data_out(wr_data_in));
    tsi_irq_status uut (.*);
    always @(posedge sys_clk_in) if (rd_en_in === 1'h1) begin
        #1 exp_w = exp_q.pop_front();
        `CHK("read", exp_w, {rd_hit_out, rd_data_out})
    end
    task rd(input [9:0] a, input [16:0] e);
        exp_q.push_back(e);
        host.acc(1'h0, a, 8'h00);
    endtask
    task set(input k, input [7:0] v);
        if (k) high_exceed_in <= v;
        else low_exceed_in <= v;
    endtask
    task ck_irq(input e);
        host.idle;
        stage_done_in <= 8'h00;
        @(posedge sys_clk_in);
        #1 `CHK("irq", e, irq_b_out)
        @(posedge sys_clk_in);
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200000 n_errors++;
        report_and_stop;
    end
    initial begin
        void'($urandom(32'h638E));
        repeat (16) @(posedge sys_clk_in);
        rst_b_in <= 1'h1;
        for (int a = 5; a < 11; a++) rd(10'(a), {a < 10, 16'h0000});
        s = 8'($urandom) | 8'h01;
        host.acc(1'h1, 10'h007, s);
        rd(10'h007, {9'h100, s});
        stage_done_in <= ~s;
        ck_irq(1'h1);
        stage_done_in <= 8'h01;
        ck_irq(1'h0);
        host.acc(1'h1, 10'h007, 8'h00);
        ck_irq(1'h1);
        for (int k = 0; k < 2; k++) begin
            s = 8'($urandom) | 8'h01;
            host.acc(1'h1, 10'(5 + k), 8'h01);
            rd(10'(5 + k), 17'h10001);
            set(k[0], s & 8'hFE);
            ck_irq(1'h1);
            set(k[0], 8'h01);
            ck_irq(1'h0);
            host.acc(1'h1, 10'(8 + k), 8'hFF);
            rd(10'(8 + k), {9'h100, s});
            rd(10'(8 + k), 17'h10001);
            set(k[0], 8'h00);
            rd(10'(8 + k), 17'h10001);
            rd(10'(8 + k), 17'h10000);
            ck_irq(1'h1);
        end
        report_and_stop;
    end
endmodule // testbench
bind tsi_irq_status tsi_irq_status_props chk (.*);
